// ==== tpw_pkg.sv ====
// Constants for the timer-driven pulse-width output block.
// Assumes a single APB clock domain; offsets are byte addresses.
package tpw_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DUTY   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_WIDE_BIT   = 0;
  localparam int CTRL_INVERT_BIT = 1;
  localparam int CTRL_INIT_BIT   = 2;
  localparam int CTRL_NEWFAM_BIT = 3;
  localparam int CTRL_SEL_LSB    = 4;
  localparam int SEL_W           = 4;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int STAT_RUN_BIT  = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_PIN_BIT  = 2;
  localparam int STAT_CNT_LSB  = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] DUTY_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Duty and period limits
  // ----------------------------------------------------------------
  localparam logic [15:0] LAST_NARROW = 16'h00ff;
  localparam logic [15:0] LAST_WIDE   = 16'hffff;
  localparam logic [15:0] FULL_NARROW = 16'h00ff;

  // ----------------------------------------------------------------
  // Timing: one tick is TICK_SCALE * 2^sel / f_MHz ns
  // ----------------------------------------------------------------
  localparam int TICK_SCALE    = 2000;
  localparam int NEW_BASE_MHZ  = 10;
  localparam int PCLK_MHZ      = 100;
  localparam int IN_CLK_MHZ    = 100;
  localparam int NS_PER_US     = 1000;
  localparam int OLD_SEL_MAX   = 7;

endpackage

// ==== tpw_top.sv ====
// Pulse-width output generator with an APB register port.
// Assumes pclk at 100 MHz and a well-behaved APB master.
module tpw_top #(
  parameter int PCLK_MHZ   = tpw_pkg::PCLK_MHZ,
  parameter int IN_CLK_MHZ = tpw_pkg::IN_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Waveform pin
  output logic             pwm_out
);

  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  localparam int OLD_BASE_NS  = tpw_pkg::TICK_SCALE / IN_CLK_MHZ;
  localparam int NEW_BASE_NS  = tpw_pkg::TICK_SCALE / tpw_pkg::NEW_BASE_MHZ;
  localparam int OLD_BASE_CYC = OLD_BASE_NS * PCLK_MHZ / tpw_pkg::NS_PER_US;
  localparam int NEW_BASE_CYC = NEW_BASE_NS * PCLK_MHZ / tpw_pkg::NS_PER_US;

  generate
    if (OLD_BASE_CYC < 1 || NEW_BASE_CYC < 1 || OLD_BASE_CYC > 65535 || NEW_BASE_CYC > 65535)
    begin : g_bad_clk
      $error("tpw_top: clock ratio gives no usable base tick");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [15:0] duty_reg;
  logic [15:0] pend_reg;
  logic        pend_vld_reg;
  logic        run_reg;
  logic        started_reg;
  logic [15:0] cnt_reg;
  logic [15:0] base_reg;
  logic [14:0] pre_reg;
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        pwm_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire         setup     = psel & ~penable;
  wire         access    = psel & penable & pready_reg;
  wire         hit_ctrl  = (paddr == tpw_pkg::OFS_CTRL);
  wire         hit_duty  = (paddr == tpw_pkg::OFS_DUTY);
  wire         hit_stat  = (paddr == tpw_pkg::OFS_STATUS);
  wire         mapped    = hit_ctrl | hit_duty | hit_stat;
  wire         wr_ctrl   = access & pwrite & hit_ctrl;
  wire         wr_duty   = access & pwrite & hit_duty;

  wire         wide      = ctrl_reg[tpw_pkg::CTRL_WIDE_BIT];
  wire         invert    = ctrl_reg[tpw_pkg::CTRL_INVERT_BIT];
  wire         init_lvl  = ctrl_reg[tpw_pkg::CTRL_INIT_BIT];
  wire         new_fam   = ctrl_reg[tpw_pkg::CTRL_NEWFAM_BIT];
  wire [3:0]   sel_raw   = ctrl_reg[tpw_pkg::CTRL_SEL_LSB +: tpw_pkg::SEL_W];

  // older family ignores sel bit 3, so sel 8-15 act as 0-7
  wire [3:0]   sel       = new_fam ? sel_raw : {1'b0, sel_raw[2:0]};

  // narrow duty masked to 8 bits
  // wide duty keeps all 16 bits
  wire [15:0]  wr_val    = wide ? pwdata[15:0] : {8'h00, pwdata[7:0]};
  wire [15:0]  last      = wide ? tpw_pkg::LAST_WIDE : tpw_pkg::LAST_NARROW;

  // ----------------------------------------------------------------
  // Tick generation
  // ----------------------------------------------------------------
  wire [15:0]  base_end  = new_fam ? 16'(NEW_BASE_CYC - 1) : 16'(OLD_BASE_CYC - 1);
  wire         base_stb  = (base_reg >= base_end);
  wire [14:0]  pre_mask  = 15'((16'h0001 << sel) - 16'h0001);
  // sel 0 ticks on every base strobe
  wire         tick      = base_stb & ((pre_reg & pre_mask) == pre_mask);
  wire         wrap      = tick & (cnt_reg >= last);

  // ----------------------------------------------------------------
  // Waveform level
  // ----------------------------------------------------------------
  // narrow 255 is the one full-on case
  wire         full_on   = ~wide & (duty_reg == tpw_pkg::FULL_NARROW);
  // wide compare has no special case
  wire         asserted  = full_on | (cnt_reg < duty_reg);
  wire         pwm_next  = ~started_reg ? init_lvl :
                           run_reg      ? (asserted ^ invert) : invert;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0]  stat_word = {cnt_reg, 13'h0000, pwm_reg, pend_vld_reg, run_reg};
  wire [31:0]  rd_mux    = hit_ctrl ? ctrl_reg :
                           hit_duty ? {16'h0000, duty_reg} :
                           hit_stat ? stat_word : 32'h0000_0000;

  // ----------------------------------------------------------------
  // APB answer, one wait-free access phase
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      prdata_reg  <= setup ? rd_mux : prdata_reg;
      pslverr_reg <= setup & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // reset value selects narrow mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= tpw_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= {24'h000000, pwdata[7:0]};
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_reg <= 16'h0000;
      pre_reg  <= 15'h0000;
    end else begin
      base_reg <= base_stb ? 16'h0000 : base_reg + 16'h0001;
      pre_reg  <= base_stb ? pre_reg + 15'h0001 : pre_reg;
    end
  end

  // ----------------------------------------------------------------
  // Duty update and period counter
  // ----------------------------------------------------------------
  // Duty writes win over the wrap so a zero is never lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_reg     <= tpw_pkg::DUTY_RST;
      pend_reg     <= tpw_pkg::DUTY_RST;
      pend_vld_reg <= 1'b0;
      run_reg      <= 1'b0;
      started_reg  <= 1'b0;
      cnt_reg      <= 16'h0000;
    end else if (wr_duty && wr_val == 16'h0000) begin
      duty_reg     <= 16'h0000;
      pend_vld_reg <= 1'b0;
      run_reg      <= 1'b0;
      started_reg  <= 1'b1;
      cnt_reg      <= 16'h0000;
    end else if (wr_duty && !run_reg) begin
      duty_reg     <= wr_val;
      pend_vld_reg <= 1'b0;
      run_reg      <= 1'b1;
      started_reg  <= 1'b1;
      cnt_reg      <= 16'h0000;
    end else begin
      if (wr_duty) begin
        pend_reg     <= wr_val;
        pend_vld_reg <= 1'b1;
      end
      if (run_reg && wrap) begin
        cnt_reg <= 16'h0000;
        if (pend_vld_reg && !wr_duty) begin
          duty_reg     <= pend_reg;
          pend_vld_reg <= 1'b0;
        end
      end else if (run_reg && tick) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin flop
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_reg <= 1'b0;
    end else begin
      pwm_reg <= pwm_next;
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;
  assign pwm_out = pwm_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire quiet = ~(access & pwrite);

  AST_ZERO_STOPS: assert property (
    wr_duty && wr_val == 16'h0000 |=> !run_reg ##1 pwm_out == invert)
    else $error("zero duty did not disable output");

  AST_IDLE_START: assert property (
    wr_duty && wr_val != 16'h0000 && !run_reg |=> run_reg && cnt_reg == 16'h0000
      && duty_reg == $past(wr_val))
    else $error("idle write did not start at once");

  AST_RUN_DEFER: assert property (
    wr_duty && wr_val != 16'h0000 && run_reg && !wrap |=> duty_reg == $past(duty_reg)
      && pend_vld_reg)
    else $error("running duty changed before cycle end");

  AST_IDLE_LEVEL: assert property (
    started_reg && !run_reg && quiet |=> pwm_out == $past(invert))
    else $error("disabled level wrong");

  AST_FULL_ON: assert property (
    run_reg && !wide && duty_reg == 16'h00ff && quiet |=> pwm_out == !$past(invert))
    else $error("narrow 255 not fully asserted");

  AST_WIDE_NEVER_FULL: assert property (
    run_reg && wide && cnt_reg >= duty_reg && quiet |=> pwm_out == $past(invert))
    else $error("wide max duty reached full on");

  AST_WIDE_KEEP: assert property (
    wr_duty && wide && !run_reg && pwdata[15:0] != 16'h0000
      |=> duty_reg == $past(pwdata[15:0]))
    else $error("wide duty not taken as sixteen bits");

  AST_NARROW_MASK: assert property (
    wr_duty && !wide && !run_reg && pwdata[7:0] != 8'h00
      |=> duty_reg == {8'h00, $past(pwdata[7:0])})
    else $error("narrow duty not taken as eight bits");

  AST_COMPARE: assert property (
    run_reg && !full_on && quiet |=> pwm_out == (($past(cnt_reg) < $past(duty_reg))
      ^ $past(invert)))
    else $error("pulse level does not follow count");

  AST_WRAP: assert property (
    run_reg && wrap && !wr_duty |=> cnt_reg == 16'h0000)
    else $error("period did not wrap at last count");

  AST_PEND_APPLY: assert property (
    run_reg && wrap && pend_vld_reg && !wr_duty |=> duty_reg == $past(pend_reg)
      && !pend_vld_reg)
    else $error("pending duty not applied at cycle end");

  AST_SEL0_FAST: assert property (
    base_stb && sel == 4'h0 |-> tick)
    else $error("select zero did not tick on every base strobe");

  AST_TICK_GAP: assert property (
    tick && new_fam && quiet |=> (!tick || !new_fam) [*8])
    else $error("newer family tick too fast");

  AST_INIT_LEVEL: assert property (
    !started_reg && quiet |=> pwm_out == $past(init_lvl))
    else $error("initial level not shown");

endmodule

// ==== tb_timer_pwm_output.sv ====
// Self-checking bench for the pulse-width output block.
// Assumes the APB slave answers before the watchdog ends and pclk at 100 MHz.
module tb_timer_pwm_output;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        pwm_out;
  logic [31:0] rd;
  logic        er;
  int          n_errors;
  int          samples_checked;

  tpw_top #(
    .PCLK_MHZ   (100),
    .IN_CLK_MHZ (100)
  ) uut (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pready  (pready),
    .prdata  (prdata),
    .pslverr (pslverr),
    .pwm_out (pwm_out)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready_wait", 32'h1, 32'(n));
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                       input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd & m);
  endtask

  task automatic pin(input logic exp, input string nm);
    repeat (3) @(negedge pclk);
    chk(nm, {31'h0, exp}, {31'h0, pwm_out});
  endtask

  // Window of whole periods, so the phase at the start does not matter
  task automatic hi(input int n, input int exp, input string nm);
    int c;
    c = 0;
    repeat (4) @(negedge pclk);
    repeat (n) begin
      @(negedge pclk);
      if (pwm_out === 1'b1) c++;
    end
    chk(nm, 32'(exp), 32'(c));
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  // Tests need about 10k cycles; 30k is the limit
  initial begin
    #300000;
    n_errors++;
    summarize();
  end

  initial begin
    n_errors = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    pin(1'b0, "pin_reset");
    rdchk(tpw_pkg::OFS_CTRL, tpw_pkg::CTRL_RST, 32'hffffffff, "ctrl");
    rdchk(tpw_pkg::OFS_DUTY, 32'h0, 32'h0000ffff, "duty_rst");
    apb(1'b0, 8'h0c, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    chk("bad_rdata", 32'h0, rd);
    wr(tpw_pkg::OFS_CTRL, 32'h4);
    pin(1'b1, "init_level");
    wr(tpw_pkg::OFS_CTRL, 32'h0);
    // duty 1 never paired with select 0
    wr(tpw_pkg::OFS_DUTY, 32'd64);
    pin(1'b1, "start_now");
    hi(512, 128, "duty64");
    wr(tpw_pkg::OFS_DUTY, 32'd255);
    repeat (520) @(posedge pclk);
    hi(512, 512, "duty255");
    wr(tpw_pkg::OFS_DUTY, 32'd128);
    rdchk(tpw_pkg::OFS_STATUS, 32'h2, 32'h2, "pending");
    rdchk(tpw_pkg::OFS_DUTY, 32'd255, 32'h0000ffff, "active_old");
    repeat (520) @(posedge pclk);
    rdchk(tpw_pkg::OFS_DUTY, 32'd128, 32'h0000ffff, "active_new");
    hi(512, 256, "duty128");
    wr(tpw_pkg::OFS_DUTY, 32'd0);
    pin(1'b0, "off_now");
    wr(tpw_pkg::OFS_CTRL, 32'h2);
    pin(1'b1, "off_inv");
    wr(tpw_pkg::OFS_DUTY, 32'd64);
    hi(512, 384, "inv64");
    wr(tpw_pkg::OFS_DUTY, 32'd0);
    wr(tpw_pkg::OFS_CTRL, 32'h10);
    wr(tpw_pkg::OFS_DUTY, 32'd64);
    hi(1024, 256, "sel1");
    wr(tpw_pkg::OFS_DUTY, 32'd0);
    wr(tpw_pkg::OFS_CTRL, 32'h8);
    wr(tpw_pkg::OFS_DUTY, 32'd16);
    hi(5120, 320, "newfam");
    wr(tpw_pkg::OFS_DUTY, 32'd0);
    wr(tpw_pkg::OFS_CTRL, 32'h1);
    wr(tpw_pkg::OFS_DUTY, 32'd300);
    repeat (580) @(posedge pclk);
    pin(1'b1, "wide_long");
    repeat (30) @(posedge pclk);
    pin(1'b0, "wide_end");
    summarize();
  end
endmodule
